// file: bench/gcf_host_model.sv
// host side model: keeps copy enable on and reactivates channels
`include "gcf_defines.svh"
`default_nettype none
module gcf_host_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic frame_loss_active,
	input wire logic [`GCF_NCHAN-1:0] chan_active,
	output logic copy_en,
	output logic [`GCF_NCHAN-1:0] chan_activate
);
	timeunit 1ns;
	timeprecision 1ns;
	assign copy_en = 1'b1;
	// one-cycle activate pulse for idle channels once framing is back
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			chan_activate <= '0;
		else if (frame_loss_active || chan_activate != '0)
			chan_activate <= '0;
		else
			chan_activate <= ~chan_active;
	end
endmodule : gcf_host_model
`default_nettype wire

// file: bench/gcf_top_test.sv
// self-checking bench for the channel-group configuration fields
`include "gcf_defines.svh"
`default_nettype none
module gcf_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic copy_en, dv, last_d, hwe, ace, fle, fre, rev, rx_accept, fla;
	gcf_pkg::gcf_cfg_s cfg_r = '0;
	gcf_pkg::gcf_cfg_s cfg_w;
	logic [3:0] dcfg = '0;
	logic [3:0] hwd = '0;
	logic [3:0] msg_cfg;
	gcf_pkg::gcf_rxerr_e kind = gcf_pkg::GCF_RXERR_ABORT;
	logic [7:0] transp = 8'h5a;
	logic [7:0] act, chan_active;
	logic [31:0] ts_en = '0;
	logic [31:0] ts_eff;
	gcf_pkg::gcf_report_s irq_desc, buf_status;
	gcf_pkg::gcf_evt_e irq_q[$], buf_q[$];
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	int seed = 68409;
	initial {dv, last_d, hwe, ace, fle, fre, rev} = '0;
	always #20 clk = ~clk;
	always_comb begin
		cfg_w = cfg_r;
		cfg_w.msg_cfg_copy_en = copy_en;
	end
	gcf_top gcf_top_inst (.clk(clk), .resetn(resetn), .cfg(cfg_w), .desc_valid(dv), .end_of_message_flag(last_d),
		.desc_cfg(dcfg), .host_cfg_we(hwe), .host_cfg_wdata(hwd), .align_change_event(ace),
		.frame_loss_event(fle), .frame_recovered_event(fre), .rx_err_valid(rev), .rx_err_kind(kind),
		.chan_transparent(transp), .chan_activate(act), .ts_subchan_en(ts_en), .msg_cfg(msg_cfg),
		.irq_desc(irq_desc), .buf_status(buf_status), .rx_accept(rx_accept), .frame_loss_active(fla),
		.ts_subchan_eff(ts_eff), .chan_active(chan_active));
	gcf_host_model gcf_host_model_inst (.clk(clk), .resetn(resetn), .frame_loss_active(fla),
		.chan_active(chan_active), .copy_en(copy_en), .chan_activate(act));
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic conclude;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	// pulse order: desc, host write, align change, loss, recovery, rx error
	task automatic ev(input logic [5:0] v);
		@(posedge clk);
		{dv, hwe, ace, fle, fre, rev} <= v;
		@(posedge clk);
		{dv, hwe, ace, fle, fre, rev} <= '0;
		repeat (5) @(posedge clk);
	endtask : ev
	// result watcher: every descriptor pops the oldest expectation
	always @(negedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			conclude();
		end else begin
			if (resetn && irq_desc.valid === 1'b1)
				check("irq_desc.code", irq_q.size() ? irq_q.pop_front() : 8'hff, irq_desc.code);
			if (resetn && buf_status.valid === 1'b1)
				check("buf_status.code", buf_q.size() ? buf_q.pop_front() : 8'hff, buf_status.code);
		end
	end
	initial begin
		logic [3:0] d, h, exp;
		gcf_pkg::gcf_evt_e e;
		exp = '0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		check("msg_cfg reset", '0, msg_cfg);
		check("rx_accept reset", 32'h0000_0001, rx_accept);
		for (int i = 0; i < 4; i++) begin
			d = 4'($random(seed));
			h = 4'($random(seed));
			@(posedge clk);
			dcfg <= d;
			hwd <= h;
			last_d <= (i != 1);
			ev({i != 2, i >= 2, 4'h0});
			exp = (i >= 2) ? h : ((i == 0) ? d : exp);
			@(negedge clk);
			check("msg_cfg", exp, msg_cfg);
		end
		for (int m = 0; m < 2; m++) begin
			@(posedge clk);
			cfg_r.align_change_irq_mask <= m[0];
			cfg_r.frame_loss_irq_mask <= m[0];
			if (m == 0)
				irq_q.push_back(gcf_pkg::GCF_EV_ALIGN_CHANGE);
			ev(6'h08);
			if (m == 0)
				irq_q.push_back(gcf_pkg::GCF_EV_FRAME_LOSS);
			ev(6'h04);
			if (m == 0)
				irq_q.push_back(gcf_pkg::GCF_EV_FRAME_RECOV);
			ev(6'h02);
			for (int k = 0; k < 3; k++) begin
				@(posedge clk);
				kind <= gcf_pkg::gcf_rxerr_e'(k);
				e = m ? gcf_pkg::GCF_EV_FRAME_LOSS_ERR : gcf_pkg::gcf_evt_e'(k + 5);
				irq_q.push_back(e);
				buf_q.push_back(e);
				ev(6'h01);
			end
		end
		for (int a = 0; a < 2; a++) begin
			@(posedge clk);
			cfg_r.frame_loss_abort_en <= a[0];
			transp <= 8'($random(seed));
			ev(6'h04);
			@(negedge clk);
			check("frame_loss_active", 32'h0000_0001, fla);
			check("rx_accept loss", !a[0], rx_accept);
			check("chan_active loss", a ? 8'(~transp) : 8'hff, chan_active);
			ev(6'h02);
			@(negedge clk);
			check("rx_accept recovered", 32'h0000_0001, rx_accept);
			check("chan_active recovered", 8'hff, chan_active);
		end
		for (int s = 0; s < 2; s++) begin
			@(posedge clk);
			ts_en <= $random(seed);
			cfg_r.subchan_disable <= s[0];
			repeat (2) @(posedge clk);
			@(negedge clk);
			check("ts_subchan_eff", s ? '0 : ts_en, ts_eff);
		end
		check("irq left", '0, irq_q.size());
		check("buf left", '0, buf_q.size());
		conclude();
	end
endmodule : gcf_top_test
`default_nettype wire

// file: hw/gcf_chan_ctl.sv
// per-channel active flag with hardware deactivation
`default_nettype none
module gcf_chan_ctl (
	input wire logic clk,
	input wire logic resetn,
	input wire logic activate,
	input wire logic deactivate,
	output logic active
);
	gcf_pkg::gcf_chan_state_s st_reg;
	gcf_pkg::gcf_chan_state_s st_next;
	always_comb begin
		st_next = st_reg;
		if (activate) begin
			st_next.active = 1'b1;
		end
		if (deactivate) begin
			st_next.active = 1'b0;
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign active = st_reg.active;
endmodule : gcf_chan_ctl
`default_nettype wire

// file: hw/gcf_defines.svh
// constants for the channel-group configuration field logic
`ifndef GCF_DEFINES_SVH
`define GCF_DEFINES_SVH
`define GCF_NCHAN 8
`define GCF_NSLOT 32
`define GCF_CFGW 4
`define GCF_MSGCFG_RST 4'h0
`define GCF_PEND_ALIGN 0
`define GCF_PEND_LOSS 1
`define GCF_PEND_RECOV 2
`define GCF_PEND_ERR 3
`endif

// file: hw/gcf_pkg.sv
// types for the channel-group configuration field logic
`default_nettype none
package gcf_pkg;
	typedef enum logic [2:0] {
		GCF_EV_NONE,
		GCF_EV_ALIGN_CHANGE,
		GCF_EV_FRAME_LOSS,
		GCF_EV_FRAME_RECOV,
		GCF_EV_FRAME_LOSS_ERR,
		GCF_EV_ABORT,
		GCF_EV_FCS,
		GCF_EV_ALIGN_ERR
	} gcf_evt_e;
	typedef enum logic [1:0] {
		GCF_RXERR_ABORT,
		GCF_RXERR_FCS,
		GCF_RXERR_ALIGN
	} gcf_rxerr_e;
	typedef struct packed {
		logic msg_cfg_copy_en;
		logic align_change_irq_mask;
		logic frame_loss_irq_mask;
		logic frame_loss_abort_en;
		logic subchan_disable;
	} gcf_cfg_s;
	typedef struct packed {
		logic valid;
		gcf_evt_e code;
	} gcf_report_s;
	typedef struct packed {
		logic active;
	} gcf_chan_state_s;
	typedef struct packed {
		logic [3:0] msg_cfg;
		logic loss_active;
		logic [3:0] pend;
		gcf_evt_e err_code;
		gcf_report_s irq;
		gcf_report_s bsd;
		logic [31:0] subchan_eff;
		logic rx_accept;
	} gcf_state_s;
endpackage : gcf_pkg
`default_nettype wire

// file: hw/gcf_top.sv
// channel-group configuration field behaviour
// Notes on behaviour
// - copy last-descriptor config bits when enabled
// - direct host config writes always accepted
// - unmasked alignment change yields interrupt descriptor
// - masked alignment change yields no descriptor
// - unmasked frame loss/recovery yields descriptor
// - masked frame loss: errors reported as frame-loss
// - abort off: keep receiving during frame loss
// - abort on: stop receive, resume on recovery
// - abort on: deactivate transparent channels on loss
// - subchannel disable clears every slot enable
`include "gcf_defines.svh"
`default_nettype none
module gcf_top (
	input wire logic clk,
	input wire logic resetn,
	input wire gcf_pkg::gcf_cfg_s cfg,
	input wire logic desc_valid,
	input wire logic end_of_message_flag,
	input wire logic [`GCF_CFGW-1:0] desc_cfg,
	input wire logic host_cfg_we,
	input wire logic [`GCF_CFGW-1:0] host_cfg_wdata,
	input wire logic align_change_event,
	input wire logic frame_loss_event,
	input wire logic frame_recovered_event,
	input wire logic rx_err_valid,
	input wire gcf_pkg::gcf_rxerr_e rx_err_kind,
	input wire logic [`GCF_NCHAN-1:0] chan_transparent,
	input wire logic [`GCF_NCHAN-1:0] chan_activate,
	input wire logic [`GCF_NSLOT-1:0] ts_subchan_en,
	output logic [`GCF_CFGW-1:0] msg_cfg,
	output gcf_pkg::gcf_report_s irq_desc,
	output gcf_pkg::gcf_report_s buf_status,
	output logic rx_accept,
	output logic frame_loss_active,
	output logic [`GCF_NSLOT-1:0] ts_subchan_eff,
	output logic [`GCF_NCHAN-1:0] chan_active
);
	gcf_pkg::gcf_state_s st_reg;
	gcf_pkg::gcf_state_s st_next;
	logic [3:0] new_pend;
	logic [3:0] issued;
	logic [`GCF_NCHAN-1:0] chan_deact;
	gcf_pkg::gcf_evt_e err_map;

	always_comb begin
		unique case (rx_err_kind)
			gcf_pkg::GCF_RXERR_ABORT: err_map = gcf_pkg::GCF_EV_ABORT;
			gcf_pkg::GCF_RXERR_FCS: err_map = gcf_pkg::GCF_EV_FCS;
			gcf_pkg::GCF_RXERR_ALIGN: err_map = gcf_pkg::GCF_EV_ALIGN_ERR;
			default: err_map = gcf_pkg::GCF_EV_ALIGN_ERR;
		endcase
		if (cfg.frame_loss_irq_mask) begin
			err_map = gcf_pkg::GCF_EV_FRAME_LOSS_ERR;
		end
	end

	always_comb begin
		new_pend = 4'h0;
		new_pend[`GCF_PEND_ALIGN] = align_change_event && !cfg.align_change_irq_mask;
		new_pend[`GCF_PEND_LOSS] = frame_loss_event && !cfg.frame_loss_irq_mask;
		new_pend[`GCF_PEND_RECOV] = frame_recovered_event && !cfg.frame_loss_irq_mask;
		new_pend[`GCF_PEND_ERR] = rx_err_valid;
		issued = 4'h0;
		if (st_reg.pend[`GCF_PEND_ALIGN]) begin
			issued[`GCF_PEND_ALIGN] = 1'b1;
		end else if (st_reg.pend[`GCF_PEND_LOSS]) begin
			issued[`GCF_PEND_LOSS] = 1'b1;
		end else if (st_reg.pend[`GCF_PEND_RECOV]) begin
			issued[`GCF_PEND_RECOV] = 1'b1;
		end else if (st_reg.pend[`GCF_PEND_ERR]) begin
			issued[`GCF_PEND_ERR] = 1'b1;
		end
	end

	always_comb begin
		st_next = st_reg;
		if (host_cfg_we) begin
			st_next.msg_cfg = host_cfg_wdata;
		end else if (cfg.msg_cfg_copy_en && desc_valid && end_of_message_flag) begin
			st_next.msg_cfg = desc_cfg;
		end
		if (frame_loss_event) begin
			st_next.loss_active = 1'b1;
		end else if (frame_recovered_event) begin
			st_next.loss_active = 1'b0;
		end
		st_next.pend = (st_reg.pend & ~issued) | new_pend;
		if (rx_err_valid) begin
			st_next.err_code = err_map;
		end
		st_next.irq.valid = |issued;
		if (issued[`GCF_PEND_ALIGN]) begin
			st_next.irq.code = gcf_pkg::GCF_EV_ALIGN_CHANGE;
		end else if (issued[`GCF_PEND_LOSS]) begin
			st_next.irq.code = gcf_pkg::GCF_EV_FRAME_LOSS;
		end else if (issued[`GCF_PEND_RECOV]) begin
			st_next.irq.code = gcf_pkg::GCF_EV_FRAME_RECOV;
		end else if (issued[`GCF_PEND_ERR]) begin
			st_next.irq.code = st_reg.err_code;
		end else begin
			st_next.irq.code = gcf_pkg::GCF_EV_NONE;
		end
		st_next.bsd.valid = rx_err_valid;
		st_next.bsd.code = rx_err_valid ? err_map : gcf_pkg::GCF_EV_NONE;
		st_next.subchan_eff = cfg.subchan_disable ? 32'h0000_0000 : ts_subchan_en;
		st_next.rx_accept = !(cfg.frame_loss_abort_en && st_next.loss_active);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
			st_reg.msg_cfg <= `GCF_MSGCFG_RST;
			st_reg.rx_accept <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign chan_deact = (frame_loss_event && cfg.frame_loss_abort_en) ? chan_transparent : '0;

	genvar gi;
	generate
		for (gi = 0; gi < `GCF_NCHAN; gi++) begin : g_chan
			gcf_chan_ctl u_chan (
				.clk(clk),
				.resetn(resetn),
				.activate(chan_activate[gi]),
				.deactivate(chan_deact[gi]),
				.active(chan_active[gi])
			);
		end
	endgenerate

	assign msg_cfg = st_reg.msg_cfg;
	assign irq_desc = st_reg.irq;
	assign buf_status = st_reg.bsd;
	assign rx_accept = st_reg.rx_accept;
	assign frame_loss_active = st_reg.loss_active;
	assign ts_subchan_eff = st_reg.subchan_eff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_copy;
		desc_valid && end_of_message_flag && cfg.msg_cfg_copy_en && !host_cfg_we |=> msg_cfg == $past(desc_cfg);
	endproperty
	a_copy: assert property (p_copy) else $error("last descriptor config not copied");

	property p_host;
		host_cfg_we |=> msg_cfg == $past(host_cfg_wdata);
	endproperty
	a_host: assert property (p_host) else $error("host config write lost");

	property p_align_on;
		align_change_event && !cfg.align_change_irq_mask |-> ##[1:2] irq_desc.valid
			&& irq_desc.code == gcf_pkg::GCF_EV_ALIGN_CHANGE;
	endproperty
	a_align_on: assert property (p_align_on) else $error("alignment change descriptor missing");

	property p_align_off;
		align_change_event && cfg.align_change_irq_mask && !st_reg.pend[`GCF_PEND_ALIGN]
			|=> !st_reg.pend[`GCF_PEND_ALIGN];
	endproperty
	a_align_off: assert property (p_align_off) else $error("masked alignment change queued");

	property p_loss_on;
		(frame_loss_event || frame_recovered_event) && !cfg.frame_loss_irq_mask
			|=> st_reg.pend[`GCF_PEND_LOSS] || st_reg.pend[`GCF_PEND_RECOV];
	endproperty
	a_loss_on: assert property (p_loss_on) else $error("frame loss event not queued");

	property p_err_map;
		rx_err_valid && cfg.frame_loss_irq_mask |=> buf_status.valid
			&& buf_status.code == gcf_pkg::GCF_EV_FRAME_LOSS_ERR;
	endproperty
	a_err_map: assert property (p_err_map) else $error("error not reported as frame loss");

	property p_keep_rx;
		!cfg.frame_loss_abort_en |=> rx_accept;
	endproperty
	a_keep_rx: assert property (p_keep_rx) else $error("receive stopped without abort");

	property p_stop_rx;
		frame_loss_event && cfg.frame_loss_abort_en |=> !rx_accept && frame_loss_active;
	endproperty
	a_stop_rx: assert property (p_stop_rx) else $error("receive not stopped on frame loss");

	property p_resume_rx;
		frame_recovered_event && !frame_loss_event && cfg.frame_loss_abort_en |=> rx_accept;
	endproperty
	a_resume_rx: assert property (p_resume_rx) else $error("receive not resumed");

	property p_deact;
		frame_loss_event && cfg.frame_loss_abort_en |=> (chan_active & $past(chan_transparent)) == '0;
	endproperty
	a_deact: assert property (p_deact) else $error("transparent channel left active");

	property p_subchan;
		cfg.subchan_disable |=> ts_subchan_eff == 32'h0000_0000;
	endproperty
	a_subchan: assert property (p_subchan) else $error("subchannel enable not overridden");
endmodule : gcf_top
`default_nettype wire
